// *** pkg/ucn_regs.svh ***
`ifndef UCN_REGS_SVH
`define UCN_REGS_SVH
// ************************************************************
// link addresses of the device registers
// ************************************************************
`define UCN_ADDR_EXT 4'h3
`define UCN_ADDR_FWD 4'h4
`define UCN_ADDR_SEL 4'h6
// field positions and writable masks
`define UCN_EXT_WIDE 0
`define UCN_EXT_PKT 1
`define UCN_FWD_LL 0
`define UCN_EXT_MASK 8'h03
`define UCN_FWD_MASK 8'h01
`define UCN_SEL_MASK 8'h7b
`define UCN_RST_VAL 8'h00
// ************************************************************
// forwarding and notification constants
// ************************************************************
`define UCN_LL_BAUD 24'd46921
`define UCN_PKT_FULL 9'd64
`define UCN_PKT_SHORT 9'd63
`define UCN_TMO_CHARS 2'd3
`define UCN_REQ_TYPE 8'b10100001
`define UCN_NTF_CODE 8'h20
`define UCN_IFACE 8'h00
`define UCN_NTF_LEN 16'h0002
`define UCN_NTF_LAST 4'd9
// ************************************************************
// host controller registers (axi4-lite byte offsets)
// ************************************************************
`define UCN_H_CMD 8'h00
`define UCN_H_RSP 8'h04
`define UCN_H_BAUD 8'h08
`define UCN_H_EVT 8'h0c
`define UCN_H_BULK 8'h10
`define UCN_H_NTF0 8'h14
`define UCN_H_NTF1 8'h18
`define UCN_H_NTF2 8'h1c
`define UCN_H_CMD_WR 16
`define UCN_FLAG_BIT 31
`endif

// *** pkg/ucn_pkg.sv ***
package ucn_pkg;
   typedef enum logic [0:0] {
      UCN_IDLE = 1'b0,
      UCN_SEND = 1'b1
   } ucn_ntf_st_t;

   typedef struct packed {
      logic [7:0] ext;
      logic [7:0] fwd;
      logic [7:0] sel;
      logic rsp_valid;
      logic [7:0] rsp_data;
      logic [5:0] s1;
      logic [5:0] s2;
      logic [5:0] s3;
      logic [5:0] pins;
      logic [3:0] line;
      logic [2:0] err;
      logic pend;
      ucn_ntf_st_t st;
      logic [3:0] idx;
      logic [15:0] status;
      logic [7:0] ntf_data;
      logic ntf_last;
      logic [8:0] rx_cnt;
      logic [1:0] idle;
      logic bulk_valid;
      logic [6:0] bulk_len;
   } ucn_dev_t;

   typedef struct packed {
      logic aw_ok;
      logic [7:0] aw_addr;
      logic w_ok;
      logic [31:0] w_data;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic req_valid;
      logic req_write;
      logic [3:0] req_addr;
      logic [7:0] req_wdata;
      logic busy;
      logic [7:0] rsp;
      logic [23:0] baud;
      logic baud_wr;
      logic acm_cmd;
      logic bulk_req;
      logic bulk_new;
      logic [6:0] bulk_len;
      logic [79:0] ntf;
      logic [3:0] ntf_cnt;
      logic ntf_new;
   } ucn_host_t;
endpackage

// *** pkg/ucn_link_if.sv ***
`timescale 1ns/1ps
interface ucn_link_if;
   logic req_valid;
   logic req_write;
   logic [3:0] req_addr;
   logic [7:0] req_wdata;
   logic rsp_valid;
   logic [7:0] rsp_rdata;
   logic acm_cmd;
   logic baud_wr;
   logic [23:0] baud_rate;
   logic bulk_req;
   logic bulk_valid;
   logic [6:0] bulk_len;
   logic ntf_valid;
   logic [7:0] ntf_data;
   logic ntf_last;
   logic ntf_ready;

   modport dev (
      input req_valid, req_write, req_addr, req_wdata, acm_cmd, baud_wr, baud_rate, bulk_req, ntf_ready,
      output rsp_valid, rsp_rdata, bulk_valid, bulk_len, ntf_valid, ntf_data, ntf_last
   );
   modport hst (
      output req_valid, req_write, req_addr, req_wdata, acm_cmd, baud_wr, baud_rate, bulk_req, ntf_ready,
      input rsp_valid, rsp_rdata, bulk_valid, bulk_len, ntf_valid, ntf_data, ntf_last
   );
endinterface

// *** hw/ucn_dev.sv ***
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "ucn_regs.svh"
// Behaviour
// RQ1 - ext bit0 selects normal or wide mode
// RQ2 - ext bit1 selects 64 or 63 byte packets
// RQ3 - acm class command forces packet bit set
// RQ4 - software writes zero to ext bits 7:2
// RQ5 - baud below 46921 sets low latency
// RQ6 - faster baud: software sets low latency itself
// RQ7 - software rewrites low latency after baud change
// RQ8 - no low latency: forward at 64 or timeout
// RQ9 - low latency: next bulk in returns all (code returns at most the 64 or 63 byte packet size)
// RQ10 - select bits enable each pin status
// RQ11 - software keeps select bits 2,7 zero
// RQ12 - packet opens with a1 then 20
// RQ13 - value zero, index interface zero
// RQ14 - length two, two data bytes follow
// RQ15 - d6 overrun, d5 parity, d4 framing
// RQ16 - d3..d0 live ring, break, dsr, carrier
// RQ17 - high byte carries selected pin states
// RQ18 - masked input pin change queues notification
// RQ19 - unselected pin positions sent as zero
// RQ20 - registers reset to zero
module ucn_dev
   import ucn_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   ucn_link_if.dev link,
   input wire logic ring_pin_io,
   input wire logic carrier_pin_io,
   input wire logic dsr_pin_io,
   input wire logic dtr_pin_io,
   input wire logic cts_pin_io,
   input wire logic rts_pin_io,
   input wire logic [5:0] pin_dir,
   input wire logic [5:0] pin_int_mask,
   input wire logic rx_push,
   input wire logic char_tick,
   input wire logic err_overrun,
   input wire logic err_parity,
   input wire logic err_framing,
   input wire logic ri_state,
   input wire logic brk_state,
   input wire logic dsr_state,
   input wire logic cd_state,
   output logic wide_en,
   output logic pkt_short,
   output logic low_lat
);
   ucn_dev_t s_r;
   ucn_dev_t s_nxt;
   logic [5:0] pin_raw;
   logic [3:0] line_now;
   logic [7:0] pin_pos;
   logic pin_evt;
   logic rx_due;
   logic [8:0] pkt_size;
   logic [8:0] fwd_len;
   logic [8:0] rx_sum;

   // ************************************************************
   // helper functions
   // ************************************************************
   // register select, shared by the write and read paths
   function automatic logic [1:0] reg_sel(input logic [3:0] a);
      case (a)
         `UCN_ADDR_EXT: reg_sel = 2'h1;
         `UCN_ADDR_FWD: reg_sel = 2'h2;
         `UCN_ADDR_SEL: reg_sel = 2'h3;
         default: reg_sel = 2'h0;
      endcase
   endfunction

   // notification byte by position, words sent low byte first
   function automatic logic [7:0] ntf_byte(input logic [3:0] i, input logic [15:0] st);
      case (i)
         4'h0: ntf_byte = `UCN_REQ_TYPE; // RQ12
         4'h1: ntf_byte = `UCN_NTF_CODE; // RQ12
         4'h2: ntf_byte = 8'h00; // RQ13
         4'h3: ntf_byte = 8'h00; // RQ13
         4'h4: ntf_byte = `UCN_IFACE; // RQ13
         4'h5: ntf_byte = 8'h00; // RQ13
         4'h6: ntf_byte = 8'(`UCN_NTF_LEN); // RQ14
         4'h7: ntf_byte = 8'h00; // RQ14
         4'h8: ntf_byte = st[7:0]; // RQ14
         4'h9: ntf_byte = st[15:8]; // RQ14
         default: ntf_byte = 8'h00;
      endcase
   endfunction

   // ************************************************************
   // pin and line inputs
   // ************************************************************
   assign pin_raw = {rts_pin_io, cts_pin_io, dtr_pin_io, dsr_pin_io, carrier_pin_io, ring_pin_io};
   assign line_now = {ri_state, brk_state, dsr_state, cd_state};
   // pin status at its select-bit position, bits 2 and 7 never carry a pin
   assign pin_pos = {1'b0, s_r.pins[5], s_r.pins[4], s_r.pins[3], s_r.pins[0], 1'b0, s_r.pins[2], s_r.pins[1]};

   // masked input change, one term per pin
   always_comb begin
      pin_evt = 1'b0;
      for (int i = 0; i < 6; i++) begin
         if (!pin_dir[i] && pin_int_mask[i] && s_r.s2[i] == s_r.s3[i] && s_r.s3[i] != s_r.pins[i]) begin
            pin_evt = 1'b1; // RQ18
         end
      end
   end

   // ************************************************************
   // receive forwarding
   // ************************************************************
   assign pkt_size = s_r.ext[`UCN_EXT_PKT] ? `UCN_PKT_SHORT : `UCN_PKT_FULL; // RQ2
   // low latency forwards any count, else a full packet or timeout
   assign rx_due = s_r.fwd[`UCN_FWD_LL] || s_r.rx_cnt >= `UCN_PKT_FULL || s_r.idle == `UCN_TMO_CHARS; // RQ8 RQ9
   assign fwd_len = !rx_due ? 9'd0 : (s_r.rx_cnt > pkt_size ? pkt_size : s_r.rx_cnt);
   assign rx_sum = s_r.rx_cnt + {8'h00, rx_push};

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      s_nxt = s_r;
      s_nxt.rsp_valid = 1'b0;
      s_nxt.bulk_valid = 1'b0;
      // three-stage pin synchroniser, a change counts once stages two and three agree
      s_nxt.s1 = pin_raw;
      s_nxt.s2 = s_r.s1;
      s_nxt.s3 = s_r.s2;
      for (int i = 0; i < 6; i++) begin
         if (s_r.s2[i] == s_r.s3[i]) begin
            s_nxt.pins[i] = s_r.s3[i];
         end
      end
      // register writes, hardware sets below win over a write in the same cycle
      if (link.req_valid && link.req_write) begin
         case (reg_sel(link.req_addr))
            2'h1: s_nxt.ext = link.req_wdata & `UCN_EXT_MASK; // RQ1 RQ2
            2'h2: s_nxt.fwd = link.req_wdata & `UCN_FWD_MASK;
            2'h3: s_nxt.sel = link.req_wdata & `UCN_SEL_MASK; // RQ10
            default: s_nxt.ext = s_nxt.ext;
         endcase
      end
      if (link.req_valid) begin
         s_nxt.rsp_valid = 1'b1;
         case (reg_sel(link.req_addr))
            2'h1: s_nxt.rsp_data = s_r.ext;
            2'h2: s_nxt.rsp_data = s_r.fwd;
            2'h3: s_nxt.rsp_data = s_r.sel;
            default: s_nxt.rsp_data = 8'h00;
         endcase
      end
      if (link.acm_cmd) begin
         s_nxt.ext[`UCN_EXT_PKT] = 1'b1; // RQ3
      end
      if (link.baud_wr && link.baud_rate < `UCN_LL_BAUD) begin
         s_nxt.fwd[`UCN_FWD_LL] = 1'b1; // RQ5
      end
      // held byte count and character-time idle counter
      s_nxt.rx_cnt = rx_sum;
      if (link.bulk_req) begin
         s_nxt.bulk_valid = 1'b1;
         s_nxt.bulk_len = fwd_len[6:0]; // RQ8 RQ9
         s_nxt.rx_cnt = rx_sum - fwd_len;
      end
      if (rx_push || s_nxt.rx_cnt == 9'd0) begin
         s_nxt.idle = 2'd0;
      end else if (char_tick && s_r.idle != `UCN_TMO_CHARS) begin
         s_nxt.idle = s_r.idle + 2'd1; // RQ8
      end
      // events to notify: the clear at packet start loses to a new event
      s_nxt.line = line_now;
      if (s_r.st == UCN_IDLE && s_r.pend) begin
         s_nxt.pend = 1'b0;
         s_nxt.err = 3'b000;
         s_nxt.st = UCN_SEND;
         s_nxt.idx = 4'h0;
         s_nxt.status[7] = 1'b0; // RQ15
         s_nxt.status[6:4] = s_r.err; // RQ15
         s_nxt.status[3:0] = line_now; // RQ16
         s_nxt.status[15:8] = s_r.sel & pin_pos; // RQ17 RQ19
         s_nxt.ntf_data = ntf_byte(4'h0, 16'h0000);
         s_nxt.ntf_last = 1'b0;
      end else if (s_r.st == UCN_SEND && link.ntf_ready) begin
         if (s_r.idx == `UCN_NTF_LAST) begin
            s_nxt.st = UCN_IDLE;
            s_nxt.ntf_last = 1'b0;
         end else begin
            s_nxt.idx = s_r.idx + 4'h1;
            s_nxt.ntf_data = ntf_byte(s_nxt.idx, s_r.status);
            s_nxt.ntf_last = (s_nxt.idx == `UCN_NTF_LAST);
         end
      end
      if (err_overrun) begin
         s_nxt.err[2] = 1'b1; // RQ15
      end
      if (err_parity) begin
         s_nxt.err[1] = 1'b1; // RQ15
      end
      if (err_framing) begin
         s_nxt.err[0] = 1'b1; // RQ15
      end
      if (err_overrun || err_parity || err_framing || line_now != s_r.line || pin_evt) begin
         s_nxt.pend = 1'b1; // RQ18
      end
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge mclk) begin
      if (rst) begin
         s_r <= '0;
         s_r.ext <= `UCN_RST_VAL; // RQ20
         s_r.fwd <= `UCN_RST_VAL; // RQ20
         s_r.sel <= `UCN_RST_VAL; // RQ20
         s_r.st <= UCN_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign link.rsp_valid = s_r.rsp_valid;
   assign link.rsp_rdata = s_r.rsp_data;
   assign link.bulk_valid = s_r.bulk_valid;
   assign link.bulk_len = s_r.bulk_len;
   assign link.ntf_valid = (s_r.st == UCN_SEND);
   assign link.ntf_data = s_r.ntf_data;
   assign link.ntf_last = s_r.ntf_last;
   assign wide_en = s_r.ext[`UCN_EXT_WIDE]; // RQ1
   assign pkt_short = s_r.ext[`UCN_EXT_PKT]; // RQ2
   assign low_lat = s_r.fwd[`UCN_FWD_LL];
endmodule

// *** hw/ucn_host.sv ***
`timescale 1ns/1ps
`include "ucn_regs.svh"
module ucn_host
   import ucn_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   ucn_link_if.hst link,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   ucn_host_t h_r;
   ucn_host_t h_nxt;

   // offset check shared by both channels
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a[1:0] == 2'b00) && (a <= `UCN_H_NTF2);
   endfunction

   // ************************************************************
   // axi4-lite slave and link master
   // ************************************************************
   always_comb begin
      h_nxt = h_r;
      h_nxt.req_valid = 1'b0;
      h_nxt.baud_wr = 1'b0;
      h_nxt.acm_cmd = 1'b0;
      h_nxt.bulk_req = 1'b0;
      if (s_axi_awvalid && !h_r.aw_ok && !h_r.bvalid) begin
         h_nxt.aw_ok = 1'b1;
         h_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !h_r.w_ok && !h_r.bvalid) begin
         h_nxt.w_ok = 1'b1;
         h_nxt.w_data = s_axi_wdata;
      end
      if (h_r.bvalid && s_axi_bready) begin
         h_nxt.bvalid = 1'b0;
      end
      // a write acts once both halves are held; strobes ignored
      if (h_r.aw_ok && h_r.w_ok && !h_r.bvalid) begin
         h_nxt.aw_ok = 1'b0;
         h_nxt.w_ok = 1'b0;
         h_nxt.bvalid = 1'b1;
         h_nxt.bresp = mapped(h_r.aw_addr) ? 2'b00 : 2'b10;
         case (h_r.aw_addr)
            `UCN_H_CMD: begin
               // software keeps reserved device bits zero, passed as written
               h_nxt.req_valid = 1'b1; // RQ4 RQ11
               h_nxt.req_wdata = h_r.w_data[7:0];
               h_nxt.req_addr = h_r.w_data[11:8];
               h_nxt.req_write = h_r.w_data[`UCN_H_CMD_WR];
               h_nxt.busy = 1'b1;
            end
            `UCN_H_BAUD: begin
               h_nxt.baud = h_r.w_data[23:0];
               h_nxt.baud_wr = 1'b1; // RQ7
            end
            `UCN_H_EVT: begin
               h_nxt.acm_cmd = h_r.w_data[0];
               h_nxt.bulk_req = h_r.w_data[1];
            end
            default: h_nxt.bresp = h_nxt.bresp;
         endcase
      end
      if (h_r.rvalid && s_axi_rready) begin
         h_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !h_r.rvalid) begin
         h_nxt.rvalid = 1'b1;
         h_nxt.rresp = mapped(s_axi_araddr) ? 2'b00 : 2'b10;
         case (s_axi_araddr)
            `UCN_H_CMD: h_nxt.rdata = {15'h0000, h_r.req_write, 4'h0, h_r.req_addr, h_r.req_wdata};
            `UCN_H_RSP: h_nxt.rdata = {23'h000000, h_r.busy, h_r.rsp};
            `UCN_H_BAUD: h_nxt.rdata = {8'h00, h_r.baud};
            `UCN_H_BULK: h_nxt.rdata = {h_r.bulk_new, 24'h000000, h_r.bulk_len};
            `UCN_H_NTF0: h_nxt.rdata = h_r.ntf[31:0];
            `UCN_H_NTF1: h_nxt.rdata = h_r.ntf[63:32];
            `UCN_H_NTF2: h_nxt.rdata = {h_r.ntf_new, 15'h0000, h_r.ntf[79:64]};
            default: h_nxt.rdata = 32'h00000000;
         endcase
         // flags clear on read, an arrival in the same cycle sets them again below
         if (s_axi_araddr == `UCN_H_BULK) begin
            h_nxt.bulk_new = 1'b0;
         end
         if (s_axi_araddr == `UCN_H_NTF2) begin
            h_nxt.ntf_new = 1'b0;
         end
      end
      // link answers
      if (link.rsp_valid) begin
         h_nxt.rsp = link.rsp_rdata;
         h_nxt.busy = 1'b0;
      end
      if (link.bulk_valid) begin
         h_nxt.bulk_len = link.bulk_len;
         h_nxt.bulk_new = 1'b1;
      end
      // notification bytes shift in at the top, the first ending lowest; held off until the last one is read
      if (link.ntf_valid && !h_r.ntf_new) begin
         h_nxt.ntf = {link.ntf_data, h_r.ntf[79:8]};
         h_nxt.ntf_cnt = link.ntf_last ? 4'h0 : h_r.ntf_cnt + 4'h1;
         h_nxt.ntf_new = link.ntf_last;
      end
   end

   // state register
   always_ff @(posedge mclk) begin
      if (rst) begin
         h_r <= '0;
      end else begin
         h_r <= h_nxt;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign s_axi_awready = !h_r.aw_ok && !h_r.bvalid;
   assign s_axi_wready = !h_r.w_ok && !h_r.bvalid;
   assign s_axi_bvalid = h_r.bvalid;
   assign s_axi_bresp = h_r.bresp;
   assign s_axi_arready = !h_r.rvalid;
   assign s_axi_rvalid = h_r.rvalid;
   assign s_axi_rdata = h_r.rdata;
   assign s_axi_rresp = h_r.rresp;
   assign link.req_valid = h_r.req_valid;
   assign link.req_write = h_r.req_write;
   assign link.req_addr = h_r.req_addr;
   assign link.req_wdata = h_r.req_wdata;
   assign link.acm_cmd = h_r.acm_cmd;
   assign link.baud_wr = h_r.baud_wr;
   assign link.baud_rate = h_r.baud;
   assign link.bulk_req = h_r.bulk_req;
   assign link.ntf_ready = !h_r.ntf_new;
endmodule

// *** dv/ucn_link_assertions.sv ***
`timescale 1ns/1ps
// ************************************************************
// link checker between host controller and device end
// ************************************************************
module ucn_link_assertions (
   input wire logic mclk,
   input wire logic rst,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [3:0] req_addr,
   input wire logic rsp_valid,
   input wire logic [7:0] rsp_rdata,
   input wire logic bulk_req,
   input wire logic bulk_valid,
   input wire logic [6:0] bulk_len,
   input wire logic ntf_valid,
   input wire logic [7:0] ntf_data,
   input wire logic ntf_last,
   input wire logic ntf_ready
);
   // byte position in the packet
   logic [3:0] idx_r;
   logic [3:0] idx_nxt;
   always_comb begin
      idx_nxt = idx_r;
      if (ntf_valid && ntf_ready) begin
         idx_nxt = ntf_last ? 4'h0 : idx_r + 4'h1;
      end
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         idx_r <= 4'h0;
      end else begin
         idx_r <= idx_nxt;
      end
   end
   default clocking dc @(posedge mclk); endclocking
   default disable iff (rst);
   property p_rsp; req_valid |=> rsp_valid; endproperty
   a_rsp: assert property (p_rsp) else $error("no answer after link request");
   property p_rsp_cause; rsp_valid |-> $past(req_valid); endproperty
   a_rsp_cause: assert property (p_rsp_cause) else $error("answer without request");
   property p_ext_resv; rsp_valid && !$past(req_write) && $past(req_addr) == 4'h3 |-> rsp_rdata[7:2] == 6'h00;
   endproperty
   a_ext_resv: assert property (p_ext_resv) else $error("ext reserved bits set");
   property p_sel_resv; rsp_valid && !$past(req_write) && $past(req_addr) == 4'h6 |-> !rsp_rdata[7] && !rsp_rdata[2];
   endproperty
   a_sel_resv: assert property (p_sel_resv) else $error("select reserved bits set");
   property p_bulk; bulk_req |=> bulk_valid; endproperty
   a_bulk: assert property (p_bulk) else $error("bulk request unanswered");
   property p_bulk_cap; bulk_valid |-> bulk_len <= 7'h40; endproperty
   a_bulk_cap: assert property (p_bulk_cap) else $error("bulk length above 64");
   property p_ntf_open; ntf_valid && idx_r == 4'h0 |-> ntf_data == 8'ha1; endproperty
   a_ntf_open: assert property (p_ntf_open) else $error("bad request type byte");
   property p_ntf_code; ntf_valid && idx_r == 4'h1 |-> ntf_data == 8'h20; endproperty
   a_ntf_code: assert property (p_ntf_code) else $error("bad notification code");
   property p_ntf_zero; ntf_valid && idx_r inside {[4'h2:4'h5]} |-> ntf_data == 8'h00; endproperty
   a_ntf_zero: assert property (p_ntf_zero) else $error("value or index not zero");
   property p_ntf_len; ntf_valid && idx_r == 4'h6 |-> ntf_data == 8'h02 ##0 1; endproperty
   a_ntf_len: assert property (p_ntf_len) else $error("bad length byte");
   property p_ntf_last; ntf_valid |-> ntf_last == (idx_r == 4'h9); endproperty
   a_ntf_last: assert property (p_ntf_last) else $error("packet not ten bytes");
   property p_ntf_hi; ntf_valid && idx_r == 4'h9 |-> !ntf_data[7] && !ntf_data[2]; endproperty
   a_ntf_hi: assert property (p_ntf_hi) else $error("reserved status bit set");
   property p_ntf_hold; ntf_valid && !ntf_ready |=> ntf_valid && $stable(ntf_data); endproperty
   a_ntf_hold: assert property (p_ntf_hold) else $error("byte dropped while stalled");
   c_bulk: cover property (bulk_valid && bulk_len != 7'h00);
   c_ntf: cover property (ntf_valid && ntf_ready && ntf_last);
   c_stall: cover property (ntf_valid && !ntf_ready);
endmodule

// *** dv/tb_uart_usb_custom_status_notify.sv ***
`timescale 1ns/1ps
`include "ucn_regs.svh"
// ************************************************************
// bench: axi4-lite host side, device side stimulus
// ************************************************************
module tb_uart_usb_custom_status_notify;
   logic mclk, rst, awready, wready, bvalid, arready, rvalid;
   logic awvalid, wvalid, bready, arvalid, rready, rx_push, char_tick, err_parity, err_overrun;
   logic ri_state, dsr_state, cd_state, wide_en, pkt_short, low_lat;
   logic [7:0] awaddr, araddr, q;
   logic [31:0] wdata, rdata, r;
   logic [1:0] bresp, rresp, lresp;
   logic [5:0] pins, pin_int_mask;
   logic [3:0] ad [3] = '{4'h3, 4'h4, 4'h6};
   logic [7:0] mk [3] = '{8'h03, 8'h01, 8'h7b};
   int n_mismatch = 0;
   int n_checks = 0;
   int i;
   ucn_link_if link();
   ucn_host u_ucn_host (.mclk(mclk), .rst(rst), .link(link), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   ucn_dev u_ucn_dev (.mclk(mclk), .rst(rst), .link(link), .ring_pin_io(pins[0]), .carrier_pin_io(pins[1]),
      .dsr_pin_io(pins[2]), .dtr_pin_io(pins[3]), .cts_pin_io(pins[4]), .rts_pin_io(pins[5]), .pin_dir(6'h00),
      .pin_int_mask(pin_int_mask), .rx_push(rx_push), .char_tick(char_tick), .err_overrun(err_overrun),
      .err_parity(err_parity), .err_framing(1'b0), .ri_state(ri_state), .brk_state(1'b0),
      .dsr_state(dsr_state), .cd_state(cd_state), .wide_en(wide_en), .pkt_short(pkt_short), .low_lat(low_lat));
   ucn_link_assertions u_chk (.mclk(mclk), .rst(rst), .req_valid(link.req_valid), .req_write(link.req_write),
      .req_addr(link.req_addr), .rsp_valid(link.rsp_valid), .rsp_rdata(link.rsp_rdata), .bulk_req(link.bulk_req),
      .bulk_valid(link.bulk_valid), .bulk_len(link.bulk_len), .ntf_valid(link.ntf_valid),
      .ntf_data(link.ntf_data), .ntf_last(link.ntf_last), .ntf_ready(link.ntf_ready));
   // 200 MHz clock
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   task chk32(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error at %0t: word got %h exp %h", $time, g, e);
      end
   endtask
   task chk8(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error at %0t: byte got %h exp %h", $time, g, e);
      end
   endtask
   // handshakes sampled at the rising edge, released just after it
   task axi_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      do begin
         @(posedge mclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask
   task axi_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do begin
         @(posedge mclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata; lresp = rresp; rready <= 1'b0;
   endtask
   // device register access, polled until not busy
   task dev_acc(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] o);
      int k;
      logic [31:0] x;
      axi_wr(`UCN_H_CMD, {15'h0000, w, 4'h0, a, d});
      x = 32'h100;
      for (k = 0; k < 10 && x[8] !== 1'b0; k++) axi_rd(`UCN_H_RSP, x);
      o = x[7:0];
   endtask
   task feed(input int np, input int nt);
      @(posedge mclk);
      if (np > 0) begin
         rx_push <= 1'b1;
         repeat (np) @(posedge mclk);
         rx_push <= 1'b0;
      end
      char_tick <= (nt > 0);
      repeat (nt) @(posedge mclk);
      char_tick <= 1'b0;
   endtask
   task bulk(input logic [6:0] n);
      axi_wr(`UCN_H_EVT, 32'h2);
      axi_rd(`UCN_H_BULK, r);
      chk32(r & 32'h8000007f, {1'b1, 24'h0, n});
   endtask
   task ntf_wait(input logic [31:0] e);
      int k;
      r = 32'h0;
      for (k = 0; k < 30 && r[31] !== 1'b1; k++) axi_rd(`UCN_H_NTF2, r);
      chk32(r & 32'h8000ffff, e);
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // the sequence needs a few hundred cycles
   initial begin
      #100000;
      n_mismatch++;
      $display("Error at %0t: watchdog expired", $time);
      end_of_test;
   end
   initial begin
      rst = 1'b1; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
      awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; rx_push = 1'b0; char_tick = 1'b0;
      err_parity = 1'b0; err_overrun = 1'b0; pins = 6'h23; pin_int_mask = 6'h00;
      ri_state = 1'b1; dsr_state = 1'b1; cd_state = 1'b0;
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      for (i = 0; i < 3; i++) begin
         dev_acc(1'b0, ad[i], 8'h00, q);
         chk8(q, 8'h00);
         dev_acc(1'b1, ad[i], 8'hff, q);
         dev_acc(1'b0, ad[i], 8'h00, q);
         chk8(q, mk[i]);
      end
      chk8({5'h0, wide_en, pkt_short, low_lat}, 8'h07);
      dev_acc(1'b1, 4'h3, 8'h00, q);
      chk8({6'h0, wide_en, pkt_short}, 8'h00);
      axi_wr(`UCN_H_EVT, 32'h1);
      dev_acc(1'b0, 4'h3, 8'h00, q);
      chk8(q, 8'h02);
      dev_acc(1'b0, 4'h5, 8'h00, q);
      chk8(q, 8'h00);
      axi_rd(8'h40, r);
      chk8({6'h0, lresp}, 8'h02);
      dev_acc(1'b1, 4'h4, 8'h00, q);
      axi_wr(`UCN_H_BAUD, 32'd46921);
      repeat (3) @(posedge mclk);
      chk8({7'h0, low_lat}, 8'h00);
      axi_wr(`UCN_H_BAUD, 32'd46920);
      repeat (3) @(posedge mclk);
      chk8({7'h0, low_lat}, 8'h01);
      dev_acc(1'b1, 4'h4, 8'h00, q);
      chk8({7'h0, low_lat}, 8'h00);
      // receive forwarding: held, timeout, full packet, short packet, low latency
      dev_acc(1'b1, 4'h3, 8'h00, q);
      feed(5, 0);
      bulk(7'd0);
      feed(0, 3);
      bulk(7'd5);
      feed(70, 0);
      bulk(7'd64);
      dev_acc(1'b1, 4'h3, 8'h02, q);
      feed(60, 0);
      bulk(7'd63);
      dev_acc(1'b1, 4'h4, 8'h01, q);
      bulk(7'd3);
      bulk(7'd0);
      // drain notifications queued since reset
      repeat (3) begin
         repeat (30) @(posedge mclk);
         axi_rd(`UCN_H_NTF2, r);
      end
      @(posedge mclk);
      err_parity <= 1'b1; err_overrun <= 1'b1;
      @(posedge mclk);
      err_parity <= 1'b0; err_overrun <= 1'b0;
      ntf_wait(32'h8000496a);
      axi_rd(`UCN_H_NTF0, r);
      chk32(r, 32'h000020a1);
      axi_rd(`UCN_H_NTF1, r);
      chk32(r, 32'h00020000);
      dev_acc(1'b1, 4'h6, 8'h00, q);
      @(posedge mclk);
      pin_int_mask <= 6'h01;
      @(posedge mclk);
      pins[0] <= 1'b0;
      ntf_wait(32'h8000000a);
      end_of_test;
   end
endmodule
